/* File: logic/ifb_pkg.sv */
// Purpose: constants for the interrupt flag, enable and priority bank
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   register offsets and the enable/priority register layout are local
package ifb_pkg;
	// register byte addresses
	localparam logic [7:0] IFB_OFF_CTRL_MAIN = 8'h00;
	localparam logic [7:0] IFB_OFF_CTRL_EDGE = 8'h04;
	localparam logic [7:0] IFB_OFF_CTRL_EXT  = 8'h08;
	localparam logic [7:0] IFB_OFF_PER_FLAGS = 8'h0C;
	localparam logic [7:0] IFB_OFF_PER_EN    = 8'h10;
	localparam logic [7:0] IFB_OFF_PER_PRIO  = 8'h14;
	localparam logic [7:0] IFB_OFF_MISC      = 8'h18;
	localparam logic [7:0] IFB_OFF_PORT_A    = 8'h1C;
	localparam logic [7:0] IFB_OFF_PORT_B    = 8'h20;
	localparam logic [7:0] IFB_OFF_CHG_EN    = 8'h24;
	localparam logic [7:0] IFB_OFF_PU_EN     = 8'h28;
	// main control bits
	localparam int IFB_B_GHEN  = 7;
	localparam int IFB_B_PLEN  = 6;
	localparam int IFB_B_T0IE  = 5;
	localparam int IFB_B_X0IE  = 4;
	localparam int IFB_B_PCIE  = 3;
	localparam int IFB_B_T0IF  = 2;
	localparam int IFB_B_X0IF  = 1;
	localparam int IFB_B_PCIF  = 0;
	// edge / pull-up / priority bits
	localparam int IFB_B_PUDIS = 7;
	localparam int IFB_B_EDG0  = 6;
	localparam int IFB_B_EDG1  = 5;
	localparam int IFB_B_EDG2  = 4;
	localparam int IFB_B_T0IP  = 2;
	localparam int IFB_B_PCIP  = 0;
	// external pin control bits
	localparam int IFB_B_X2IP  = 7;
	localparam int IFB_B_X1IP  = 6;
	localparam int IFB_B_X2IE  = 4;
	localparam int IFB_B_X1IE  = 3;
	localparam int IFB_B_X2IF  = 1;
	localparam int IFB_B_X1IF  = 0;
	// peripheral flag bits
	localparam int IFB_B_CVDF  = 6;
	localparam int IFB_B_RXIF  = 5;
	localparam int IFB_B_TXEF  = 4;
	localparam int IFB_B_SSIF  = 3;
	localparam int IFB_B_CCIF  = 2;
	localparam int IFB_B_T2IF  = 1;
	localparam int IFB_B_T1IF  = 0;
	// misc control: priority enable at bit 0
	localparam int IFB_B_PLVL  = 0;
	// implemented-bit masks and reset values
	localparam logic [7:0] IFB_MSK_MAIN  = 8'hFF;
	localparam logic [7:0] IFB_MSK_EDGE  = 8'hF5;
	localparam logic [7:0] IFB_MSK_EXT   = 8'hDB;
	localparam logic [7:0] IFB_MSK_PER   = 8'h7F;
	localparam logic [7:0] IFB_MSK_PERW  = 8'h4F;
	localparam logic [7:0] IFB_RST_MAIN  = 8'h00;
	localparam logic [7:0] IFB_RST_EDGE  = 8'hF5;
	localparam logic [7:0] IFB_RST_EXT   = 8'hC0;
	localparam logic [7:0] IFB_RST_PER   = 8'h00;
	localparam logic [7:0] IFB_RST_PPRIO = 8'h7F;
	localparam logic [7:0] IFB_RST_ZERO  = 8'h00;
	localparam logic [5:0] IFB_MSK_PA    = 6'h3F;
	localparam logic [3:0] IFB_MSK_PB    = 4'hF;
	// capture/compare modes
	typedef enum logic [1:0] {
		IFB_CC_CAPTURE = 2'h0,
		IFB_CC_COMPARE = 2'h1,
		IFB_CC_PWM     = 2'h2
	} ifb_cc_mode_e;
	typedef enum logic [1:0] {
		IFB_BUS_IDLE = 2'b01,
		IFB_BUS_ACK  = 2'b10
	} ifb_bus_e;
endpackage : ifb_pkg

/* File: logic/ifb_evt_if.sv */
// Purpose: carrier between the bank and its edge / change detectors
// Assumes: single clock
// Notes:   pulses are one cycle wide
`timescale 1ns/1ns
interface ifb_evt_if;
	logic [2:0] ext_edge_sel;
	logic [2:0] ext_evt;
	logic [5:0] pa_en;
	logic [3:0] pb_en;
	logic       port_read;
	logic       mismatch;
	modport det (input ext_edge_sel, input pa_en, input pb_en, input port_read,
		output ext_evt, output mismatch);
	modport bank (output ext_edge_sel, output pa_en, output pb_en, output port_read,
		input ext_evt, input mismatch);
endinterface : ifb_evt_if

/* File: logic/ifb_ext_edge.sv */
// Purpose: qualifying edge detection on the three external pins
// Assumes: pins synchronous to clk_i
// Notes:   changing the edge select may itself look like an edge; clear flag after
`timescale 1ns/1ns
module ifb_ext_edge (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// pins
	input  wire logic [2:0] ext_pin_i,
	// bank side
	ifb_evt_if.det    ev
);
	import ifb_pkg::*;
	logic [2:0] act_q;
	wire  [2:0] act_now = ~(ext_pin_i ^ ev.ext_edge_sel);
	// reset as active so a pin already at its active level gives no false edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_q <= 3'h7;
		end else begin
			act_q <= act_now;
		end
	end
	assign ev.ext_evt  = act_now & ~act_q;
	// no port change work on this carrier
	assign ev.mismatch = 1'b0;
endmodule : ifb_ext_edge

/* File: logic/ifb_port_change.sv */
// Purpose: port change mismatch detector on port A 5..0 and port B 7..4
// Assumes: a bus read of either port relatches both ports
// Notes:   mismatch is a level and re-sets the flag each cycle it lasts
`timescale 1ns/1ns
module ifb_port_change (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// pins
	input  wire logic [5:0] port_a_i,
	input  wire logic [3:0] port_b_i,
	// bank side
	ifb_evt_if.det    ev
);
	import ifb_pkg::*;
	logic [5:0] pa_q;
	logic [3:0] pb_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_q <= 6'h00;
			pb_q <= 4'h0;
		end else if (ev.port_read) begin
			pa_q <= port_a_i;
			pb_q <= port_b_i;
		end
	end
	// only pins with their change enable set count
	assign ev.mismatch = |((pa_q ^ port_a_i) & ev.pa_en) | |((pb_q ^ port_b_i) & ev.pb_en);
	assign ev.ext_evt = 3'h0;
endmodule : ifb_port_change

/* File: logic/ifb_bank.sv */
// Purpose: interrupt flag, enable and priority register bank with request outputs
// Assumes: classic wishbone slave, one wait-free ack cycle after request
// Notes:   peripheral enable/priority registers are kept here to gate peripherals
`timescale 1ns/1ns
// Contract
// - no priorities: bit7 gates every source
// - priorities: bit7 high enable, clear blocks all
// - no priorities: bit6 gates peripheral sources
// - priorities: bit6 gates low sources
// - timer zero flag bit2, enable bit5
// - pin zero flag bit1, enable bit4
// - port change flag bit0, enable bit3
// - mismatch keeps re-setting; software reads ports
// - change needs per-pin enable bit
// - bit7 disables pull-ups; else input and bit
// - edge selects bits 6,5,4, reset rising
// - priorities timer zero bit2, change bit0
// - pins 2,1 priority bits7,6, enables 4,3
// - pin 2 flag bit1, pin 1 bit0
// - flags set regardless of enables
// - unimplemented bits read zero, writes ignored
// - converter done flag bit6 sticky
// - receive flag bit5 read-only, buffer full
// - transmit flag bit4 read-only, buffer empty
// - serial, timer two, timer one flags
// - capture/compare flag, unused in pulse mode
// - priority operation only with priority enable
// - acceptance clears the level's global enable
module ifb_bank (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// source events
	input  wire logic                  timer_zero_ovf_i,
	input  wire logic [2:0]            ext_pin_i,
	input  wire logic [5:0]            port_a_i,
	input  wire logic [3:0]            port_b_i,
	input  wire logic [5:0]            port_a_input_i,
	input  wire logic [3:0]            port_b_input_i,
	input  wire logic                  converter_done_i,
	input  wire logic                  serial_rx_full_i,
	input  wire logic                  serial_tx_empty_i,
	input  wire logic                  sync_serial_done_i,
	input  wire logic                  cc_event_i,
	input  wire ifb_pkg::ifb_cc_mode_e cc_mode_i,
	input  wire logic                  timer_two_match_i,
	input  wire logic                  timer_one_ovf_i,
	// core handshake
	input  wire logic                  accept_high_i,
	input  wire logic                  accept_low_i,
	input  wire logic                  return_i,
	// outputs
	output logic                       irq_high_o,
	output logic                       irq_low_o,
	output logic                       serial_rx_read_o,
	output logic                       serial_tx_write_o,
	output logic      [5:0]            port_a_pullup_o,
	output logic      [3:0]            port_b_pullup_o
);
	import ifb_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] msk);
		wr_merge = (old & ~msk) | (nw & msk);
	endfunction : wr_merge

	logic [7:0] main_q, edge_q, ext_q, per_q, pen_q, ppr_q, misc_q;
	logic [7:0] chg_a_q, chg_b_q, pu_a_q, pu_b_q;
	logic [7:0] main_d, ext_d, per_d;
	logic       ack_q;
	logic       hiact_q;
	logic [31:0] rd_q;
	logic       irq_h_q, irq_l_q, rxr_q, txw_q;
	logic [5:0] pua_q;
	logic [3:0] pub_q;

	ifb_evt_if ev_ext ();
	ifb_evt_if ev_chg ();

	////////////////////////////////////////////////////////////////////////////////
	// bus decode
	wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr       = req & wb_we_i & wb_sel_i[0];
	wire rd       = req & ~wb_we_i;
	wire [7:0] wd = wb_dat_i[7:0];
	wire sel_main = wb_adr_i == IFB_OFF_CTRL_MAIN;
	wire sel_edge = wb_adr_i == IFB_OFF_CTRL_EDGE;
	wire sel_ext  = wb_adr_i == IFB_OFF_CTRL_EXT;
	wire sel_per  = wb_adr_i == IFB_OFF_PER_FLAGS;
	wire sel_pen  = wb_adr_i == IFB_OFF_PER_EN;
	wire sel_ppr  = wb_adr_i == IFB_OFF_PER_PRIO;
	wire sel_misc = wb_adr_i == IFB_OFF_MISC;
	wire sel_pa   = wb_adr_i == IFB_OFF_PORT_A;
	wire sel_pb   = wb_adr_i == IFB_OFF_PORT_B;
	wire sel_chg  = wb_adr_i == IFB_OFF_CHG_EN;
	wire sel_pu   = wb_adr_i == IFB_OFF_PU_EN;

	////////////////////////////////////////////////////////////////////////////////
	// detectors
	assign ev_ext.ext_edge_sel = {edge_q[IFB_B_EDG2], edge_q[IFB_B_EDG1], edge_q[IFB_B_EDG0]};
	assign ev_ext.pa_en        = 6'h00;
	assign ev_ext.pb_en        = 4'h0;
	assign ev_ext.port_read    = 1'b0;
	assign ev_chg.ext_edge_sel = 3'h7;
	assign ev_chg.pa_en        = chg_a_q[5:0] & IFB_MSK_PA;
	assign ev_chg.pb_en        = chg_b_q[3:0] & IFB_MSK_PB;
	// reading either port ends the mismatch
	assign ev_chg.port_read    = rd & (sel_pa | sel_pb);

	ifb_ext_edge u_ext (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ext_pin_i (ext_pin_i),
		.ev        (ev_ext.det)
	);
	ifb_port_change u_chg (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.port_a_i (port_a_i),
		.port_b_i (port_b_i),
		.ev       (ev_chg.det)
	);

	////////////////////////////////////////////////////////////////////////////////
	// flag updates: write first, then hardware sets win over clears
	wire prio_on = misc_q[IFB_B_PLVL];
	wire cc_set = cc_event_i & (cc_mode_i != IFB_CC_PWM);
	wire [7:0] main_w = (wr & sel_main) ? wr_merge(main_q, wd, IFB_MSK_MAIN) : main_q;
	wire [7:0] ext_w  = (wr & sel_ext)  ? wr_merge(ext_q, wd, IFB_MSK_EXT) : ext_q;
	wire [7:0] per_w  = (wr & sel_per)  ? wr_merge(per_q, wd, IFB_MSK_PERW) : per_q;

	always_comb begin
		main_d = main_w;
		// sets ignore enables so software can poll
		if (timer_zero_ovf_i)
			main_d[IFB_B_T0IF] = 1'b1;
		if (ev_ext.ext_evt[0])
			main_d[IFB_B_X0IF] = 1'b1;
		if (ev_chg.mismatch)
			main_d[IFB_B_PCIF] = 1'b1;
		// acceptance drops the level's enable, return restores it
		if (accept_high_i | (accept_low_i & ~prio_on))
			main_d[IFB_B_GHEN] = 1'b0;
		else if (accept_low_i & prio_on)
			main_d[IFB_B_PLEN] = 1'b0;
		if (return_i & (hiact_q | ~prio_on))
			main_d[IFB_B_GHEN] = 1'b1;
		else if (return_i)
			main_d[IFB_B_PLEN] = 1'b1;
		ext_d = ext_w;
		if (ev_ext.ext_evt[2])
			ext_d[IFB_B_X2IF] = 1'b1;
		if (ev_ext.ext_evt[1])
			ext_d[IFB_B_X1IF] = 1'b1;
		per_d = per_w;
		if (converter_done_i)
			per_d[IFB_B_CVDF] = 1'b1;
		if (sync_serial_done_i)
			per_d[IFB_B_SSIF] = 1'b1;
		if (timer_two_match_i)
			per_d[IFB_B_T2IF] = 1'b1;
		if (timer_one_ovf_i)
			per_d[IFB_B_T1IF] = 1'b1;
		if (cc_set)
			per_d[IFB_B_CCIF] = 1'b1;
		// serial flags mirror buffer state and ignore writes
		per_d[IFB_B_RXIF] = serial_rx_full_i;
		per_d[IFB_B_TXEF] = serial_tx_empty_i;
		per_d[7] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// request forming
	wire [6:0] src_act = {
		per_q[6:0] & pen_q[6:0] & IFB_MSK_PER[6:0]
	};
	wire [4:0] core_act = {
		ext_q[IFB_B_X2IF] & ext_q[IFB_B_X2IE],
		ext_q[IFB_B_X1IF] & ext_q[IFB_B_X1IE],
		main_q[IFB_B_T0IF] & main_q[IFB_B_T0IE],
		main_q[IFB_B_X0IF] & main_q[IFB_B_X0IE],
		main_q[IFB_B_PCIF] & main_q[IFB_B_PCIE]
	};
	// pin zero is always high priority
	wire [4:0] core_pri = {
		ext_q[IFB_B_X2IP], ext_q[IFB_B_X1IP], edge_q[IFB_B_T0IP], 1'b1, edge_q[IFB_B_PCIP]
	};
	wire any_core  = |core_act;
	wire any_per   = |src_act;
	wire hi_pend   = |(core_act & core_pri) | |(src_act & ppr_q[6:0]);
	wire lo_pend   = |(core_act & ~core_pri) | |(src_act & ~ppr_q[6:0]);
	wire glb_en    = main_q[IFB_B_GHEN];
	wire grp_en    = main_q[IFB_B_PLEN];
	// compatibility: all on the high line, peripherals need the group enable
	wire compat_rq = glb_en & (any_core | (grp_en & any_per));
	wire irq_h_d   = prio_on ? (glb_en & hi_pend) : compat_rq;
	wire irq_l_d   = prio_on & glb_en & grp_en & lo_pend;
	// pull-up only on input pins with their bit, unless globally disabled
	wire [5:0] pua_d = edge_q[IFB_B_PUDIS] ? 6'h00 : (pu_a_q[5:0] & port_a_input_i);
	wire [3:0] pub_d = edge_q[IFB_B_PUDIS] ? 4'h0 : (pu_b_q[3:0] & port_b_input_i);

	////////////////////////////////////////////////////////////////////////////////
	// read mux, unimplemented bits zero
	wire [7:0] rd_byte =
		sel_main ? main_q :
		sel_edge ? (edge_q & IFB_MSK_EDGE) :
		sel_ext  ? (ext_q & IFB_MSK_EXT) :
		sel_per  ? (per_q & IFB_MSK_PER) :
		sel_pen  ? (pen_q & IFB_MSK_PER) :
		sel_ppr  ? (ppr_q & IFB_MSK_PER) :
		sel_misc ? {7'h00, misc_q[0]} :
		sel_pa   ? {2'h0, port_a_i} :
		sel_pb   ? {port_b_i, 4'h0} :
		sel_chg  ? {2'h0, chg_a_q[5:0]} :
		sel_pu   ? {pu_b_q[3:0], 4'h0} | {2'h0, pu_a_q[5:0]} : 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_q  <= IFB_RST_MAIN;
			edge_q  <= IFB_RST_EDGE;
			ext_q   <= IFB_RST_EXT;
			per_q   <= IFB_RST_PER;
			pen_q   <= IFB_RST_ZERO;
			ppr_q   <= IFB_RST_PPRIO;
			misc_q  <= IFB_RST_ZERO;
			chg_a_q <= IFB_RST_ZERO;
			chg_b_q <= IFB_RST_ZERO;
			pu_a_q  <= IFB_RST_ZERO;
			pu_b_q  <= IFB_RST_ZERO;
		end else begin
			main_q <= main_d;
			ext_q  <= ext_d;
			per_q  <= per_d;
			if (wr & sel_edge)
				edge_q <= wr_merge(edge_q, wd, IFB_MSK_EDGE);
			if (wr & sel_pen)
				pen_q <= wd & IFB_MSK_PER;
			if (wr & sel_ppr)
				ppr_q <= wd & IFB_MSK_PER;
			if (wr & sel_misc)
				misc_q <= {7'h00, wd[IFB_B_PLVL]};
			if (wr & sel_chg) begin
				chg_a_q <= {2'h0, wd[5:0]};
				chg_b_q <= {4'h0, wb_dat_i[11:8]};
			end
			if (wr & sel_pu) begin
				pu_a_q <= {2'h0, wd[5:0]};
				pu_b_q <= {4'h0, wd[7:4]};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q   <= 1'b0;
			rd_q    <= 32'h0000_0000;
			hiact_q <= 1'b0;
			irq_h_q <= 1'b0;
			irq_l_q <= 1'b0;
			rxr_q   <= 1'b0;
			txw_q   <= 1'b0;
			pua_q   <= 6'h00;
			pub_q   <= 4'h0;
		end else begin
			ack_q   <= req;
			rd_q    <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			hiact_q <= accept_high_i ? 1'b1 : (return_i ? 1'b0 : hiact_q);
			irq_h_q <= irq_h_d;
			irq_l_q <= irq_l_d;
			rxr_q   <= rd & sel_per;
			txw_q   <= wr & sel_per;
			pua_q   <= pua_d;
			pub_q   <= pub_d;
		end
	end

	assign wb_ack_o          = ack_q;
	assign wb_dat_o          = rd_q;
	assign irq_high_o        = irq_h_q;
	assign irq_low_o         = irq_l_q;
	assign serial_rx_read_o  = rxr_q;
	assign serial_tx_write_o = txw_q;
	assign port_a_pullup_o   = pua_q;
	assign port_b_pullup_o   = pub_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_t0_evt;
		timer_zero_ovf_i;
	endsequence
	chk_t0_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		s_t0_evt |=> main_q[IFB_B_T0IF]) else $error("timer zero flag not set");
	chk_x1_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		ev_ext.ext_evt[1] |=> ext_q[IFB_B_X1IF]) else $error("pin one flag not set");
	chk_glb_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
		!glb_en |=> !irq_high_o && !irq_low_o) else $error("request with global enable low");
	chk_low_needs_prio: assert property (@(posedge clk_i) disable iff (rst_i)
		!prio_on |=> !irq_low_o) else $error("low request in compatibility mode");
	chk_per_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		(!prio_on && !grp_en && !any_core) |=> !irq_high_o) else $error("peripheral not gated");
	chk_accept_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(accept_high_i && !return_i) |=> !main_q[IFB_B_GHEN]) else $error("enable not cleared");
	chk_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && sel_edge) |=> (wb_dat_o[3] == 1'b0) && (wb_dat_o[1] == 1'b0))
		else $error("unimplemented bit nonzero");
	chk_mismatch_set: assert property (@(posedge clk_i) disable iff (rst_i)
		ev_chg.mismatch[*2] |=> main_q[IFB_B_PCIF]) else $error("mismatch did not re-set flag");
	chk_rx_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 per_q[IFB_B_RXIF] == $past(serial_rx_full_i)) else $error("receive flag wrong");
	chk_pullup_off: assert property (@(posedge clk_i) disable iff (rst_i)
		edge_q[IFB_B_PUDIS] |=> port_a_pullup_o == 6'h00) else $error("pull-up while disabled");
	chk_pullup_b_off: assert property (@(posedge clk_i) disable iff (rst_i)
		edge_q[IFB_B_PUDIS] |=> port_b_pullup_o == 4'h0) else $error("pull-up while disabled");
	chk_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o) else $error("bus request not acknowledged");
	chk_cc_pwm_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		(cc_mode_i == IFB_CC_PWM && !per_q[IFB_B_CCIF] && !(wr && sel_per))
		|=> !per_q[IFB_B_CCIF]) else $error("capture flag set in pulse mode");
	chk_t1_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		(per_q[IFB_B_T1IF] && !(wr && sel_per)) |=> per_q[IFB_B_T1IF])
		else $error("timer one flag lost");
	chk_x2_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		(ext_q[IFB_B_X2IF] && !(wr && sel_ext)) |=> ext_q[IFB_B_X2IF])
		else $error("pin two flag lost");
	chk_high_req: assert property (@(posedge clk_i) disable iff (rst_i)
		(prio_on && glb_en && |(core_act & core_pri)) |=> irq_high_o)
		else $error("no high request");
	chk_pin0_high: assert property (@(posedge clk_i) disable iff (rst_i)
		(glb_en && main_q[IFB_B_X0IF] && main_q[IFB_B_X0IE]) |=> irq_high_o)
		else $error("pin zero not on high line");
	chk_tx_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 per_q[IFB_B_TXEF] == $past(serial_tx_empty_i)) else $error("transmit flag wrong");
	chk_per_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && sel_per) |=> !wb_dat_o[7]) else $error("unimplemented flag bit set");
endmodule : ifb_bank

/* File: test/ifb_core_model.sv */
// Purpose: stand-in for the core's interrupt sequencing next to the bank
// Assumes: one clock, accept and return are one-cycle pulses
// Notes:   accepts at once, returns ret_dly_i + 1 cycles after the accept; high wins over low
`timescale 1ns/1ns
module ifb_core_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// bench control
	input  wire logic       armed_i,
	input  wire logic [3:0] ret_dly_i,
	// bank side
	input  wire logic       irq_high_i,
	input  wire logic       irq_low_i,
	output logic            accept_high_o,
	output logic            accept_low_o,
	output logic            return_o
);
	logic       busy_q;
	logic [3:0] cnt_q;
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		accept_high_o <= 1'b0;
		accept_low_o  <= 1'b0;
		return_o      <= 1'b0;
		if (rst_i) begin
			busy_q <= 1'b0;
			cnt_q  <= 4'h0;
		end else if (!busy_q) begin
			if (armed_i && (irq_high_i || irq_low_i)) begin
				// high first so a pending high request is never hidden by a low one
				accept_high_o <= irq_high_i;
				accept_low_o  <= !irq_high_i;
				busy_q        <= 1'b1;
				cnt_q         <= ret_dly_i;
			end
		end else if (cnt_q == 4'h0) begin
			return_o <= 1'b1;
			busy_q   <= 1'b0;
		end else begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule : ifb_core_model

/* File: test/ifb_bank_bench.sv */
// Purpose: self-checking bench for the interrupt flag, enable and priority bank
// Assumes: classic wishbone single cycles, one byte per word
// Notes:   compatibility mode requests are expected on irq_high_o
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
	checked++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("[FAIL] %s expected %h seen %h", nm, exp, got); \
	end \
end
module ifb_bank_bench;
	import ifb_pkg::*;
	logic         clk_i, rst_i, cyc, stb, we, armed, ah, al, rt, irq_h, irq_l;
	logic         rx_full, tx_empty, rx_rd, tx_wr, ack;
	logic [7:0]   adr;
	logic [3:0]   sel, lanes, pb, pb_in, pb_pu, ret_dly;
	logic [31:0]  dat, dat_o;
	logic [2:0]   pins;
	logic [5:0]   pa, pa_in, pa_pu, pv;
	ifb_cc_mode_e cc_mode;
	int           n_fail, checked, n_rx, n_tx;
	logic [7:0]   ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h2C};
	logic [7:0]   re [8] = '{8'h00, 8'hF5, 8'hC0, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h00};
	////////////////////////////////////////////////////////////////////////////////
	ifb_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .timer_zero_ovf_i(pv[5]), .ext_pin_i(pins), .port_a_i(pa),
		.port_b_i(pb), .port_a_input_i(pa_in), .port_b_input_i(pb_in),
		.converter_done_i(pv[4]), .serial_rx_full_i(rx_full), .serial_tx_empty_i(tx_empty),
		.sync_serial_done_i(pv[3]), .cc_event_i(pv[2]), .cc_mode_i(cc_mode),
		.timer_two_match_i(pv[1]), .timer_one_ovf_i(pv[0]), .accept_high_i(ah),
		.accept_low_i(al), .return_i(rt), .irq_high_o(irq_h), .irq_low_o(irq_l),
		.serial_rx_read_o(rx_rd), .serial_tx_write_o(tx_wr), .port_a_pullup_o(pa_pu),
		.port_b_pullup_o(pb_pu));
	ifb_core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .armed_i(armed),
		.ret_dly_i(ret_dly), .irq_high_i(irq_h), .irq_low_i(irq_l), .accept_high_o(ah),
		.accept_low_o(al), .return_o(rt));
	always #5 clk_i = ~clk_i;
	// count buffer access strobes, each stands one cycle
	always @(posedge clk_i) begin
		if (rx_rd === 1'b1) n_rx <= n_rx + 1;
		if (tx_wr === 1'b1) n_tx <= n_tx + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wt
	// waits on a model pulse; a hang counts as a mismatch
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 50) begin
			n_fail++;
			$display("[FAIL] core handshake timeout");
			wrap_up();
		end
	endtask : wait_hi
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= {24'h0, d};
		sel <= lanes;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 20) begin
			n_fail++;
			$display("[FAIL] wishbone ack timeout");
			wrap_up();
		end
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		`CHK(nm, e, q)
	endtask : rchk
	task automatic pulse(input logic [5:0] m);
		@(posedge clk_i);
		pv <= m;
		@(posedge clk_i);
		pv <= 6'h00;
		wt(3);
	endtask : pulse
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF; dat = 0;
		pv = 0; pins = 0; pa = 0; pb = 0; pa_in = 6'h3F; pb_in = 4'hF; rx_full = 0;
		tx_empty = 0; cc_mode = IFB_CC_CAPTURE; armed = 0; ret_dly = 4'h1;
		n_fail = 0; checked = 0; n_rx = 0; n_tx = 0; lanes = 4'hF;
		wt(12);
		rst_i <= 1'b0;
		wr(8'h2C, 8'hFF);
		for (int i = 0; i < 8; i++) rchk(ra[i], re[i], "reset value");
		wr(8'h08, 8'hFF);
		rchk(8'h08, 8'hDB, "ext reserved bits");
		lanes = 4'hE;
		wr(8'h18, 8'h01);
		lanes = 4'hF;
		rchk(8'h18, 8'h00, "lane zero off");
		wr(8'h08, 8'hC0);
		$display("test reset done");
		// compatibility: priority bit low must not matter
		wr(8'h04, 8'hF1);
		pulse(6'h20);
		rchk(8'h00, 8'h04, "t0 flag polled");
		wr(8'h00, 8'h24);
		wt(2);
		`CHK("irq no global", 1'b0, irq_h)
		wr(8'h00, 8'hA4);
		wt(2);
		`CHK("irq t0 compat", 1'b1, irq_h)
		wr(8'h00, 8'h00);
		pulse(6'h10);
		wr(8'h10, 8'h40);
		wr(8'h00, 8'h80);
		wt(2);
		`CHK("irq periph no group", 1'b0, irq_h)
		wr(8'h00, 8'hC0);
		wt(2);
		`CHK("irq periph group", 1'b1, irq_h)
		wr(8'h00, 8'h40);
		wt(2);
		`CHK("irq periph no global", 1'b0, irq_h)
		rchk(8'h0C, 8'h40, "converter flag");
		wr(8'h0C, 8'h00);
		wr(8'h00, 8'h00);
		$display("test compat done");
		// priority levels: timer zero low, then high
		wr(8'h18, 8'h01);
		pulse(6'h20);
		wr(8'h00, 8'hA4);
		wt(2);
		`CHK("low blocked by gl", 1'b0, irq_l)
		wr(8'h00, 8'hE4);
		wt(2);
		`CHK("low request", 1'b1, irq_l)
		`CHK("no high for low", 1'b0, irq_h)
		wr(8'h00, 8'h64);
		wt(2);
		`CHK("low blocked by gh", 1'b0, irq_l)
		wr(8'h04, 8'hF5);
		wr(8'h00, 8'hA4);
		wt(2);
		`CHK("high request", 1'b1, irq_h)
		ret_dly <= 4'h6;
		armed <= 1'b1;
		wait_hi(ah);
		armed <= 1'b0;
		rchk(8'h00, 8'h24, "accept clears gh");
		wait_hi(rt);
		wt(2);
		rchk(8'h00, 8'hA4, "return sets gh");
		wr(8'h00, 8'h00);
		$display("test priority done");
		// external pins, then pin two on falling edge
		pins <= 3'b111;
		wt(3);
		rchk(8'h00, 8'h02, "pin zero flag");
		rchk(8'h08, 8'hC3, "pin 1 2 flags");
		wr(8'h04, 8'hE5);
		wr(8'h08, 8'hC0);
		wr(8'h00, 8'h00);
		pins <= 3'b011;
		wt(3);
		rchk(8'h08, 8'hC2, "pin two falling");
		wr(8'h00, 8'hC0);
		wr(8'h08, 8'h52);
		wt(2);
		`CHK("pin two low prio", 1'b1, irq_l)
		`CHK("pin two not high", 1'b0, irq_h)
		armed <= 1'b1;
		wait_hi(al);
		armed <= 1'b0;
		rchk(8'h00, 8'h80, "accept clears gl");
		wait_hi(rt);
		wt(2);
		rchk(8'h00, 8'hC0, "return sets gl");
		wr(8'h08, 8'hC0);
		wr(8'h00, 8'h00);
		wr(8'h18, 8'h00);
		$display("test ext pins done");
		// port change on enabled pin zero only
		wr(8'h24, 8'h01);
		pa <= 6'h02;
		wt(3);
		rchk(8'h00, 8'h00, "masked pin change");
		pa <= 6'h03;
		wt(3);
		rchk(8'h00, 8'h01, "port change flag");
		wr(8'h00, 8'h00);
		rchk(8'h00, 8'h01, "mismatch re-sets");
		rchk(8'h1C, 8'h03, "port a read");
		pb <= 4'hA;
		rchk(8'h20, 8'hA0, "port b read");
		wr(8'h00, 8'h00);
		rchk(8'h00, 8'h00, "flag stays clear");
		$display("test port change done");
		// pull-ups gated by disable bit and pin direction
		wr(8'h28, 8'h33);
		wt(2);
		`CHK("pullups disabled", 6'h00, pa_pu)
		wr(8'h04, 8'h75);
		pa_in <= 6'h0F;
		wt(3);
		`CHK("pullups port a", 6'h03, pa_pu)
		`CHK("pullups port b", 4'h3, pb_pu)
		wr(8'h04, 8'hF5);
		$display("test pullups done");
		// peripheral flags, read-only serial bits, capture modes
		rx_full <= 1'b1;
		tx_empty <= 1'b1;
		pulse(6'h0F);
		rchk(8'h0C, 8'h3F, "periph flags");
		wr(8'h0C, 8'h00);
		rchk(8'h0C, 8'h30, "serial read-only");
		rx_full <= 1'b0;
		tx_empty <= 1'b0;
		cc_mode <= IFB_CC_PWM;
		pulse(6'h04);
		rchk(8'h0C, 8'h00, "cc unused in pwm");
		cc_mode <= IFB_CC_COMPARE;
		pulse(6'h04);
		rchk(8'h0C, 8'h04, "cc compare");
		$display("test peripherals done");
		wt(1);
		`CHK("rx read pulses", 6, n_rx)
		`CHK("tx write pulses", 2, n_tx)
		wrap_up();
	end
endmodule : ifb_bank_bench
